// >>> hw/overhead_defines.svh
// Offsets, frame positions, codes and timing figures for the overhead block.
`ifndef OVERHEAD_DEFINES_SVH
`define OVERHEAD_DEFINES_SVH
`define FRAME_ROWS 4'd9
`define FRAME_COLS 9'd270
`define OH_COLS 9'd9
`define RSOH_ROWS 4'd3
`define PAR_ROW 4'd4
`define PAR_LANES 9'd3
`define K2_ROW 4'd4
`define K2_COL 9'd6
`define M1_ROW 4'd8
`define M1_COL 9'd8
`define F1_ROW 4'd1
`define F1_COL 9'd3
`define RDI_CODE 3'h6
`define AIS_CODE 3'h7
`define NORMAL_CODE 3'h0
`define REI_SET 8'h01
`define REI_CLEAR 8'h00
`define REI_MAX 7'h18
`define PERSIST_MIN 3'h3
`define PERSIST_MAX 3'h5
`define ALL_ONES 8'hff
`define REG_STATUS 8'h00
`define REG_MASK 8'h04
`define REG_DEFECTS 8'h08
`define EV_NEAR 0
`define EV_FAR 1
`define EV_AIS 2
`define EV_DEG 3
`define EV_RDI 4
`define EV_COUNT 5
`define FRAME_TIME_US 125
`define ACTION_TIME_US 250
`endif

// >>> hw/overhead_pkg.sv
// Types shared by the overhead block: byte slot classes and their decoder.
`include "overhead_defines.svh"
package overhead_pkg;
  typedef enum {slot_payload, slot_rsoh, slot_f1, slot_par, slot_k2,
    slot_m1} overhead_slot_type;

  function automatic overhead_slot_type slot_of(input logic [3:0] row,
      input logic [8:0] col);
    overhead_slot_type s;
    s = slot_payload;
    if (row < `RSOH_ROWS && col < `OH_COLS) begin
      s = (row == `F1_ROW && col == `F1_COL) ? slot_f1 : slot_rsoh;
    end else if (row == `PAR_ROW && col < `PAR_LANES) begin
      s = slot_par;
    end else if (row == `K2_ROW && col == `K2_COL) begin
      s = slot_k2;
    end else if (row == `M1_ROW && col == `M1_COL) begin
      s = slot_m1;
    end
    return s;
  endfunction : slot_of
endpackage : overhead_pkg

// >>> hw/persist_filter.sv
// Consecutive-sample persistence filter with a runtime count.
`timescale 1ns/1ns
module persist_filter #(
  parameter int CW = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic level,
  input wire logic [CW-1:0] need,
  output logic state
);
  logic [CW-1:0] run_r;
  logic [CW-1:0] run_nxt;
  logic state_r;
  logic state_nxt;

  if (CW < 2) begin : g_check
    $error("persist_filter needs a count width of at least two bits");
  end

  always_comb begin
    run_nxt = run_r;
    state_nxt = state_r;
    if (tick) begin
      if (level == state_r) begin
        run_nxt = '0;
      end else if (run_r + 1'b1 >= need) begin
        // A count of zero acts as one so the filter never locks up.
        state_nxt = level;
        run_nxt = '0;
      end else begin
        run_nxt = run_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= '0;
      state_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      state_r <= state_nxt;
    end
  end

  assign state = state_r;
endmodule : persist_filter

// >>> hw/section_overhead_trail.sv
// Multiplex-section overhead inserter and monitor with a register port.
// Notes on behaviour
// - Inserter writes 01 into M1 when monitor saw parity errors, else 00.
// - Inserter sends 110 in K2 bits 6-8 while the alarm defect holds, else 000.
// - Inserter puts even interleaved parity of last frame, minus RSOH, in B2.
// - Monitor recomputes that parity and flags any B2 mismatch per frame.
// - Monitor takes M1 each frame as far-end errored block indication.
// - M1 bits 2-8 of 1 to 24 mean one errored block, others none.
// - The top bit of M1 is ignored when decoding.
// - K2 bits 6-8 of 110 mean remote defect, anything else normal.
// - Monitor extracts the alarm pattern from K2 bits 6-8 every frame.
// - Alarm set after x frames of 111, cleared after x others, x 3..5.
// - Degrade detected using threshold and period inputs; remote defect taken from each K2.
// - Frames are 9 by 270 octets, 125 us, timed by the link clock.
// - Inserter places the user channel octet into F1 once per frame.
// - While the alarm defect holds the monitor sends all ones on rx_data_out.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`include "overhead_defines.svh"
module section_overhead_trail #(
  parameter int DEG_W = 16
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic tx_fs_in,
  input wire logic [7:0] tx_data_in,
  input wire logic [7:0] user_channel_data,
  output logic tx_fs_out,
  output logic [7:0] tx_data_out,
  input wire logic rx_fs_in,
  input wire logic [7:0] rx_data_in,
  output logic rx_fs_out,
  output logic [7:0] rx_data_out,
  input wire logic server_fail_in,
  input wire logic one_second_tick,
  input wire logic [2:0] alarm_persist_frames,
  input wire logic [DEG_W-1:0] degrade_threshold,
  input wire logic [3:0] degrade_period_count,
  input wire logic monitor_enable_mode,
  input wire logic alarm_report_enable,
  input wire logic far_defect_report_enable,
  input wire logic signal_fail_report_enable,
  output logic trail_fail_out,
  output logic near_errored_block,
  output logic far_errored_block,
  output logic alarm_indication_defect,
  output logic signal_degraded_defect,
  output logic far_defect_received,
  output logic remote_error_to_source,
  output logic remote_defect_to_source,
  output logic alarm_report,
  output logic degrade_report,
  output logic far_defect_report,
  output logic signal_fail_report,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq
);
  if (DEG_W < 2 || DEG_W > 32) begin : g_check
    $error("DEG_W must lie between 2 and 32");
  end

  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // All link pins share one synchroniser, so they keep their relative timing.
  logic [18:0] pins;
  logic [18:0] pin_meta_r;
  logic [18:0] pin_r;
  logic link_prev_r;
  assign pins = {link_clk, tx_fs_in, tx_data_in, rx_fs_in, rx_data_in};
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= '0;
      pin_r <= '0;
      link_prev_r <= 1'b0;
    end else begin
      pin_meta_r <= pins;
      pin_r <= pin_meta_r;
      link_prev_r <= pin_r[18];
    end
  end

  logic byte_en;
  logic txs_fs;
  logic [7:0] txs_d;
  logic rxs_fs;
  logic [7:0] rxs_d;
  assign byte_en = pin_r[18] & ~link_prev_r;
  assign txs_fs = pin_r[17];
  assign txs_d = pin_r[16:9];
  assign rxs_fs = pin_r[8];
  assign rxs_d = pin_r[7:0];

  logic ais_r;
  logic deg_r;
  logic rdi_r;
  logic rei_r;

  // Inserter side.
  logic [3:0] tx_row_r, tx_row_nxt;
  logic [8:0] tx_col_r, tx_col_nxt;
  logic [2:0][7:0] tx_bip_r, tx_bip_nxt;
  logic [2:0][7:0] tx_par_r, tx_par_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;
  logic tx_fs_r, tx_fs_nxt;

  always_comb begin
    logic [3:0] row;
    logic [8:0] col;
    logic [1:0] lane;
    logic [7:0] ob;
    overhead_pkg::overhead_slot_type slot;
    row = txs_fs ? 4'h0 : tx_row_r;
    col = txs_fs ? 9'h0 : tx_col_r;
    lane = 2'(col % `PAR_LANES);
    slot = overhead_pkg::slot_of(row, col);
    ob = txs_d;
    tx_row_nxt = tx_row_r;
    tx_col_nxt = tx_col_r;
    tx_bip_nxt = tx_bip_r;
    tx_par_nxt = tx_par_r;
    tx_data_nxt = tx_data_r;
    tx_fs_nxt = tx_fs_r;
    unique case (slot)
      overhead_pkg::slot_par: ob = tx_par_r[lane];
      overhead_pkg::slot_k2:
        ob = {txs_d[7:3], rdi_src() ? `RDI_CODE : `NORMAL_CODE};
      overhead_pkg::slot_m1: ob = rei_r ? `REI_SET : `REI_CLEAR;
      overhead_pkg::slot_f1: ob = user_channel_data;
      overhead_pkg::slot_rsoh, overhead_pkg::slot_payload: ob = txs_d;
    endcase
    if (byte_en) begin
      tx_data_nxt = ob;
      tx_fs_nxt = txs_fs;
      if (row == 4'h0 && col == 9'h0) begin
        tx_par_nxt = tx_bip_r;
        tx_bip_nxt = '0;
      end
      if (slot != overhead_pkg::slot_rsoh && slot != overhead_pkg::slot_f1) begin
        tx_bip_nxt[lane] = tx_bip_nxt[lane] ^ ob;
      end
      tx_col_nxt = (col == `FRAME_COLS - 9'd1) ? 9'h0 : col + 9'd1;
      tx_row_nxt = (col != `FRAME_COLS - 9'd1) ? row :
        (row == `FRAME_ROWS - 4'd1) ? 4'h0 : row + 4'd1;
    end
  end

  function automatic logic rdi_src();
    return ais_r;
  endfunction : rdi_src

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_row_r <= '0;
      tx_col_r <= '0;
      tx_bip_r <= '0;
      tx_par_r <= '0;
      tx_data_r <= '0;
      tx_fs_r <= 1'b0;
    end else begin
      tx_row_r <= tx_row_nxt;
      tx_col_r <= tx_col_nxt;
      tx_bip_r <= tx_bip_nxt;
      tx_par_r <= tx_par_nxt;
      tx_data_r <= tx_data_nxt;
      tx_fs_r <= tx_fs_nxt;
    end
  end

  // Monitor side.
  logic [3:0] rx_row_r, rx_row_nxt;
  logic [8:0] rx_col_r, rx_col_nxt;
  logic [2:0][7:0] rx_bip_r, rx_bip_nxt;
  logic [2:0][7:0] rx_par_r, rx_par_nxt;
  logic rx_err_r, rx_err_nxt;
  logic [7:0] rx_data_r, rx_data_nxt;
  logic rx_fs_r, rx_fs_nxt;
  logic near_r, near_nxt;
  logic far_r, far_nxt;
  logic rei_nxt;
  logic rdi_nxt;
  logic k2_tick;
  logic k2_ais;
  logic [DEG_W-1:0] deg_cnt_r, deg_cnt_nxt;

  always_comb begin
    logic [3:0] row;
    logic [8:0] col;
    logic [1:0] lane;
    logic mism;
    overhead_pkg::overhead_slot_type slot;
    row = rxs_fs ? 4'h0 : rx_row_r;
    col = rxs_fs ? 9'h0 : rx_col_r;
    lane = 2'(col % `PAR_LANES);
    slot = overhead_pkg::slot_of(row, col);
    mism = (lane != 2'h0 && rx_err_r) || (rxs_d != rx_par_r[lane]);
    rx_row_nxt = rx_row_r;
    rx_col_nxt = rx_col_r;
    rx_bip_nxt = rx_bip_r;
    rx_par_nxt = rx_par_r;
    rx_err_nxt = rx_err_r;
    rx_data_nxt = rx_data_r;
    rx_fs_nxt = rx_fs_r;
    near_nxt = 1'b0;
    far_nxt = 1'b0;
    rei_nxt = rei_r;
    rdi_nxt = rdi_r;
    k2_tick = 1'b0;
    k2_ais = 1'b0;
    if (byte_en) begin
      rx_data_nxt = ais_r ? `ALL_ONES : rxs_d;
      rx_fs_nxt = rxs_fs;
      if (row == 4'h0 && col == 9'h0) begin
        rx_par_nxt = rx_bip_r;
        rx_bip_nxt = '0;
      end
      if (slot != overhead_pkg::slot_rsoh && slot != overhead_pkg::slot_f1) begin
        rx_bip_nxt[lane] = rx_bip_nxt[lane] ^ rxs_d;
      end
      unique case (slot)
        overhead_pkg::slot_par: begin
          rx_err_nxt = mism;
          if (lane == 2'h2) begin
            near_nxt = mism;
            rei_nxt = mism;
          end
        end
        overhead_pkg::slot_k2: begin
          k2_tick = 1'b1;
          k2_ais = rxs_d[2:0] == `AIS_CODE;
          rdi_nxt = rxs_d[2:0] == `RDI_CODE;
        end
        overhead_pkg::slot_m1:
          far_nxt = rxs_d[6:0] != 7'h0 && rxs_d[6:0] <= `REI_MAX;
        overhead_pkg::slot_rsoh, overhead_pkg::slot_f1,
        overhead_pkg::slot_payload: far_nxt = 1'b0;
      endcase
      rx_col_nxt = (col == `FRAME_COLS - 9'd1) ? 9'h0 : col + 9'd1;
      rx_row_nxt = (col != `FRAME_COLS - 9'd1) ? row :
        (row == `FRAME_ROWS - 4'd1) ? 4'h0 : row + 4'd1;
    end
    if (one_second_tick) begin
      deg_cnt_nxt = '0;
    end else if (near_r && deg_cnt_r != '1) begin
      deg_cnt_nxt = deg_cnt_r + 1'b1;
    end else begin
      deg_cnt_nxt = deg_cnt_r;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_row_r <= '0;
      rx_col_r <= '0;
      rx_bip_r <= '0;
      rx_par_r <= '0;
      rx_err_r <= 1'b0;
      rx_data_r <= '0;
      rx_fs_r <= 1'b0;
      near_r <= 1'b0;
      far_r <= 1'b0;
      rei_r <= 1'b0;
      rdi_r <= 1'b0;
      deg_cnt_r <= '0;
    end else begin
      rx_row_r <= rx_row_nxt;
      rx_col_r <= rx_col_nxt;
      rx_bip_r <= rx_bip_nxt;
      rx_par_r <= rx_par_nxt;
      rx_err_r <= rx_err_nxt;
      rx_data_r <= rx_data_nxt;
      rx_fs_r <= rx_fs_nxt;
      near_r <= near_nxt;
      far_r <= far_nxt;
      rei_r <= rei_nxt;
      rdi_r <= rdi_nxt;
      deg_cnt_r <= deg_cnt_nxt;
    end
  end

  // Out-of-range persistence settings are clamped rather than refused.
  logic [2:0] persist;
  assign persist = (alarm_persist_frames < `PERSIST_MIN) ? `PERSIST_MIN :
    (alarm_persist_frames > `PERSIST_MAX) ? `PERSIST_MAX :
    alarm_persist_frames;

  persist_filter #(.CW(3)) u_ais (
    .clock(clock),
    .rst_n(rst_n),
    .tick(k2_tick),
    .level(k2_ais),
    .need(persist),
    .state(ais_r)
  );

  persist_filter #(.CW(4)) u_deg (
    .clock(clock),
    .rst_n(rst_n),
    .tick(one_second_tick),
    .level(deg_cnt_r > degrade_threshold),
    .need(degrade_period_count),
    .state(deg_r)
  );

  // Register port, sticky events and reports.
  logic [`EV_COUNT-1:0] status_r, status_nxt;
  logic [`EV_COUNT-1:0] mask_r, mask_nxt;
  logic [2:0] prev_def_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic [3:0] rep_r, rep_nxt;
  logic [`EV_COUNT-1:0] ev;

  always_comb begin
    ev = '0;
    ev[`EV_NEAR] = near_r;
    ev[`EV_FAR] = far_r;
    ev[`EV_AIS] = ais_r ^ prev_def_r[0];
    ev[`EV_DEG] = deg_r ^ prev_def_r[1];
    ev[`EV_RDI] = rdi_r ^ prev_def_r[2];
    status_nxt = status_r;
    mask_nxt = mask_r;
    if (reg_write && reg_addr == `REG_STATUS) begin
      status_nxt = status_r & ~reg_wdata[`EV_COUNT-1:0];
    end
    // An event in the clearing cycle survives the clear.
    status_nxt = status_nxt | ev;
    if (reg_write && reg_addr == `REG_MASK) begin
      mask_nxt = reg_wdata[`EV_COUNT-1:0];
    end
    rdata_nxt = '0;
    if (reg_read) begin
      unique case (reg_addr)
        `REG_STATUS: rdata_nxt = 32'(status_r);
        `REG_MASK: rdata_nxt = 32'(mask_r);
        `REG_DEFECTS: rdata_nxt = {28'h0, rei_r, rdi_r, deg_r, ais_r};
        default: rdata_nxt = '0;
      endcase
    end
    rep_nxt[0] = monitor_enable_mode && ais_r && !server_fail_in &&
      alarm_report_enable;
    rep_nxt[1] = monitor_enable_mode && deg_r;
    rep_nxt[2] = monitor_enable_mode && rdi_r && far_defect_report_enable;
    rep_nxt[3] = monitor_enable_mode && ais_r && signal_fail_report_enable;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= '0;
      mask_r <= '0;
      prev_def_r <= '0;
      rdata_r <= '0;
      rep_r <= '0;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      prev_def_r <= {rdi_r, deg_r, ais_r};
      rdata_r <= rdata_nxt;
      rep_r <= rep_nxt;
    end
  end

  assign tx_fs_out = tx_fs_r;
  assign tx_data_out = tx_data_r;
  assign rx_fs_out = rx_fs_r;
  assign rx_data_out = rx_data_r;
  assign trail_fail_out = ais_r;
  assign near_errored_block = near_r;
  assign far_errored_block = far_r;
  assign alarm_indication_defect = ais_r;
  assign signal_degraded_defect = deg_r;
  assign far_defect_received = rdi_r;
  assign remote_error_to_source = rei_r;
  assign remote_defect_to_source = ais_r;
  assign alarm_report = rep_r[0];
  assign degrade_report = rep_r[1];
  assign far_defect_report = rep_r[2];
  assign signal_fail_report = rep_r[3];
  assign reg_rdata = rdata_r;
  assign irq = |(status_r & mask_r);
endmodule : section_overhead_trail

// >>> dv/section_overhead_trail_monitor.sv
// Concurrent checks on the overhead block's ports.
`timescale 1ns/1ns
module section_overhead_trail_monitor (
  input wire logic clock,
  input wire logic rstn,
  input wire logic server_fail_in,
  input wire logic monitor_enable_mode,
  input wire logic alarm_report_enable,
  input wire logic far_defect_report_enable,
  input wire logic signal_fail_report_enable,
  input wire logic trail_fail_out,
  input wire logic near_errored_block,
  input wire logic far_errored_block,
  input wire logic alarm_indication_defect,
  input wire logic signal_degraded_defect,
  input wire logic far_defect_received,
  input wire logic remote_defect_to_source,
  input wire logic alarm_report,
  input wire logic degrade_report,
  input wire logic far_defect_report,
  input wire logic signal_fail_report
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_near; near_errored_block |=> !near_errored_block; endproperty
  a_near: assert property (p_near) else $error("near pulse too long");
  property p_far; far_errored_block |=> !far_errored_block; endproperty
  a_far: assert property (p_far) else $error("far pulse too long");
  property p_tsf; trail_fail_out == alarm_indication_defect; endproperty
  a_tsf: assert property (p_tsf) else $error("trail fail differs");
  property p_rds; remote_defect_to_source == alarm_indication_defect;
  endproperty
  a_rds: assert property (p_rds) else $error("defect hand-over");
  property p_arep; alarm_report == $past(monitor_enable_mode &&
    alarm_indication_defect && !server_fail_in && alarm_report_enable);
  endproperty
  a_arep: assert property (p_arep) else $error("alarm report");
  property p_drep;
    degrade_report == $past(monitor_enable_mode && signal_degraded_defect);
  endproperty
  a_drep: assert property (p_drep) else $error("degrade report");
  property p_frep; far_defect_report == $past(monitor_enable_mode &&
    far_defect_received && far_defect_report_enable);
  endproperty
  a_frep: assert property (p_frep) else $error("far report");
  property p_srep; signal_fail_report == $past(monitor_enable_mode &&
    alarm_indication_defect && signal_fail_report_enable);
  endproperty
  a_srep: assert property (p_srep) else $error("fail report");
  // The alarm can only move on a K2 byte, so it never flickers.
  property p_ais; $changed(alarm_indication_defect) |=>
    $stable(alarm_indication_defect)[*8]; endproperty
  a_ais: assert property (p_ais) else $error("alarm flicker");
endmodule : section_overhead_trail_monitor

bind section_overhead_trail section_overhead_trail_monitor
  section_overhead_trail_monitor_inst (.clock(clock), .rstn(rstn),
  .server_fail_in(server_fail_in), .monitor_enable_mode(monitor_enable_mode),
  .alarm_report_enable(alarm_report_enable),
  .far_defect_report_enable(far_defect_report_enable),
  .signal_fail_report_enable(signal_fail_report_enable),
  .trail_fail_out(trail_fail_out), .near_errored_block(near_errored_block),
  .far_errored_block(far_errored_block),
  .alarm_indication_defect(alarm_indication_defect),
  .signal_degraded_defect(signal_degraded_defect),
  .far_defect_received(far_defect_received),
  .remote_defect_to_source(remote_defect_to_source),
  .alarm_report(alarm_report), .degrade_report(degrade_report),
  .far_defect_report(far_defect_report),
  .signal_fail_report(signal_fail_report));

// >>> dv/link_partner.sv
// Link-side source model: link clock, frame start and bytes with parity.
`timescale 1ns/1ns
module link_partner (
  output logic link_clk,
  output logic fs,
  output logic [7:0] data
);
  logic [23:0] par;
  logic [23:0] acc;
  initial begin
    link_clk = 1'b0;
    fs = 1'b0;
    data = 8'h00;
    acc = 24'h0;
  end
  // The link clock stands low between frames; a frame may be cut short.
  task automatic send_frame(input logic [2:0] k2, input logic [7:0] m1,
      input logic bad, input int n);
    logic [7:0] b;
    par = acc;
    acc = 24'h0;
    for (int i = 0; i < n; i++) begin
      b = i[7:0] ^ 8'ha5;
      if (i >= 1080 && i <= 1082) b = par[8*(i%3) +: 8] ^ {7'h0, bad};
      if (i == 1086) b = {5'h15, k2};
      if (i == 2168) b = m1;
      if (!(i < 810 && i % 270 < 9)) acc[8*(i%3) +: 8] ^= b;
      fs = (i == 0);
      data = b;
      #40 link_clk = 1'b1;
      #40 link_clk = 1'b0;
    end
  endtask : send_frame
endmodule : link_partner

// >>> dv/section_overhead_trail_tb_top.sv
// Self-checking bench for the overhead inserter and monitor.
`timescale 1ns/1ns
module section_overhead_trail_tb_top;
  logic clock, rstn, link_clk, fs, tx_fs_out, rx_fs_out, tick, sfail, mon;
  logic sfen, near, far, ais, deg, fdr, rei, rds, tsf, arep, drep, frep, srep;
  logic reg_write, reg_read, irq;
  logic [7:0] data, user, tx_data_out, rx_data_out, reg_addr, tx_m1, rx_mid;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [23:0] tpar = 24'h0, tacc = 24'h0;
  logic [2:0] tx_k2;
  int error_cnt = 0, tests_run = 0, near_cnt = 0, far_cnt = 0, pos = 5000;

  link_partner link_partner_inst (.link_clk(link_clk), .fs(fs), .data(data));
  section_overhead_trail section_overhead_trail_inst (.clock(clock),
    .rstn(rstn), .link_clk(link_clk), .tx_fs_in(fs), .tx_data_in(data),
    .user_channel_data(user), .tx_fs_out(tx_fs_out),
    .tx_data_out(tx_data_out), .rx_fs_in(fs), .rx_data_in(data),
    .rx_fs_out(rx_fs_out), .rx_data_out(rx_data_out),
    .server_fail_in(sfail), .one_second_tick(tick),
    .alarm_persist_frames(3'h3), .degrade_threshold(16'h0000),
    .degrade_period_count(4'h1), .monitor_enable_mode(mon),
    .alarm_report_enable(1'b1), .far_defect_report_enable(1'b1),
    .signal_fail_report_enable(sfen), .trail_fail_out(tsf),
    .near_errored_block(near), .far_errored_block(far),
    .alarm_indication_defect(ais), .signal_degraded_defect(deg),
    .far_defect_received(fdr), .remote_error_to_source(rei),
    .remote_defect_to_source(rds), .alarm_report(arep),
    .degrade_report(drep), .far_defect_report(frep),
    .signal_fail_report(srep), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .irq(irq));

  always #5 clock = ~clock;
  always @(posedge clock) begin
    if (near === 1'b1) near_cnt++;
    if (far === 1'b1) far_cnt++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Outputs hold a byte until the next byte, so each link edge sees the last.
  always @(posedge link_clk) begin
    if (tx_fs_out === 1'b1) begin
      pos = 0;
      tpar = tacc;
      tacc = 24'h0;
    end
    chk(32'(rx_fs_out), 32'(pos == 0));
    if (pos >= 1080 && pos <= 1082)
      chk({24'h0, tx_data_out}, {24'h0, tpar[8*(pos%3) +: 8]});
    if (pos == 273) chk({24'h0, tx_data_out}, {24'h0, user});
    if (pos == 1086) tx_k2 = tx_data_out[2:0];
    if (pos == 2168) tx_m1 = tx_data_out;
    if (pos == 1000) rx_mid = rx_data_out;
    if (!(pos < 810 && pos % 270 < 9)) tacc[8*(pos%3) +: 8] ^= tx_data_out;
    pos++;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_clk

  task automatic frm(input logic [2:0] k2, input logic [7:0] m1,
      input logic bad, input int n);
    link_partner_inst.send_frame(k2, m1, bad, n);
    wait_clk(4);
  endtask : frm

  task automatic pulse_tick;
    @(posedge clock);
    tick <= 1'b1;
    @(posedge clock);
    tick <= 1'b0;
    wait_clk(3);
  endtask : pulse_tick

  task automatic report_and_stop;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #1000000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    {tick, sfail, sfen, reg_write, reg_read} = 5'h00;
    mon = 1'b1;
    user = 8'h3c;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    wait_clk(3);
    // Short frames stop just past K2 to keep the run brief.
    frm(3'h0, 8'h00, 1'b1, 1088);
    pulse_tick();
    chk(32'(deg), 32'h1);
    chk(32'(drep), 32'h1);
    wr(8'h00, 32'h1f);
    wr(8'h04, 32'h01);
    rd(8'h04, d);
    chk(d, 32'h1);
    near_cnt = 0;
    far_cnt = 0;
    frm(3'h6, 8'h98, 1'b1, 2170);
    chk(32'(near_cnt), 32'h1);
    chk(32'(far_cnt), 32'h1);
    chk(32'(fdr), 32'h1);
    chk(32'(frep), 32'h1);
    chk(32'(rei), 32'h1);
    chk({24'h0, tx_m1}, 32'h01);
    chk(32'(irq), 32'h1);
    rd(8'h00, d);
    chk(d, 32'h13);
    rd(8'h08, d);
    chk(d, 32'he);
    rd(8'h40, d);
    chk(d, 32'h0);
    wr(8'h00, 32'h1f);
    wait_clk(2);
    chk(32'(irq), 32'h0);
    mon <= 1'b0;
    wait_clk(2);
    chk(32'(frep), 32'h0);
    mon <= 1'b1;
    pulse_tick();
    frm(3'h0, 8'h19, 1'b0, 2170);
    chk(32'(near_cnt), 32'h1);
    chk(32'(far_cnt), 32'h1);
    chk(32'(fdr), 32'h0);
    chk(32'(rei), 32'h0);
    chk({24'h0, rx_mid}, 32'h4d);
    chk(32'(tx_k2), 32'h0);
    pulse_tick();
    chk(32'(deg), 32'h0);
    user <= 8'h96;
    repeat (2) frm(3'h7, 8'h00, 1'b0, 1088);
    chk(32'(ais), 32'h0);
    frm(3'h7, 8'h00, 1'b0, 1088);
    chk(32'(ais), 32'h1);
    chk(32'(tsf), 32'h1);
    chk(32'(rds), 32'h1);
    chk(32'(arep), 32'h1);
    chk(32'(srep), 32'h0);
    rd(8'h08, d);
    chk(d, 32'h1);
    sfen <= 1'b1;
    sfail <= 1'b1;
    wait_clk(2);
    chk(32'(srep), 32'h1);
    chk(32'(arep), 32'h0);
    sfail <= 1'b0;
    frm(3'h0, 8'h00, 1'b0, 1088);
    chk(32'(ais), 32'h1);
    chk({24'h0, rx_mid}, 32'hff);
    chk(32'(tx_k2), 32'h6);
    frm(3'h0, 8'h00, 1'b0, 1088);
    frm(3'h0, 8'h00, 1'b0, 1088);
    chk(32'(ais), 32'h0);
    report_and_stop();
  end
endmodule : section_overhead_trail_tb_top
